/* pkg/fsrds_pkg.sv */
// Contract
// - reset aborts work, restores power-on state
// - enable and reset accepted in both modes
// - reset only directly after reset-enable
// - recovery period rejects all commands
// - host checks busy and suspend first; fsrds_host sends reset without checking
// - deep sleep ignores every command
// - deep sleep entered after select rises
// - bits after deep sleep code ignored
// - misaligned select rise abandons entry
// - power-up lands in standby
// - deep sleep refused while array busy
// - host wakes with long select pulse
// - dummy byte in wake pulse discarded
// - operations during exit time ignored
// - host waits for standby before commands
package fsrds_pkg;
  localparam int CLK_NS = 4;
  localparam logic [7:0] CMD_RST_EN = 8'h66;
  localparam logic [7:0] CMD_RST = 8'h99;
  localparam logic [7:0] CMD_DEEP = 8'h79;
  localparam int RST_RECOV_NS = 28000;
  localparam int RST_RECOV_CYC = (RST_RECOV_NS + CLK_NS - 1) / CLK_NS;
  localparam int DEEP_ENTRY_NS = 3000;
  localparam int DEEP_ENTRY_CYC = DEEP_ENTRY_NS / CLK_NS;
  localparam int DEEP_EXIT_NS = 3000;
  localparam int DEEP_EXIT_CYC = DEEP_EXIT_NS / CLK_NS;
  localparam int WAKE_LOW_NS = 200;
  localparam int WAKE_LOW_CYC = (WAKE_LOW_NS + CLK_NS - 1) / CLK_NS;
  localparam int CMD_GAP_CYC = 4;
  localparam int SCLK_HALF_CYC = 2;
  localparam int TMR_W = 16;
  localparam logic [11:0] CMD_OFS = 12'h000;
  localparam logic [11:0] STAT_OFS = 12'h004;
  localparam int CMD_QUAD_BIT = 8;
  localparam int CMD_WAKE_BIT = 9;
  localparam int CMD_DUMMY_BIT = 10;
  localparam logic [11:0] CMD_RESET_VAL = 12'h000;
  localparam logic [7:0] PARAM_RESET_VAL = 8'h00;
  localparam logic [2:0] WRAP_RESET_VAL = 3'h0;
  localparam logic [4:0] SYNC_RESET_VAL = 5'h10;
  typedef enum logic [2:0] {
    ST_STANDBY = 3'h0,
    ST_RECOVER = 3'h1,
    ST_ENTERING = 3'h2,
    ST_DEEP = 3'h3,
    ST_WAKING = 3'h4
  } fsrds_dev_state_t;
  typedef enum logic [1:0] {
    H_IDLE = 2'h0,
    H_SHIFT = 2'h1,
    H_LOW = 2'h2,
    H_HOLD = 2'h3
  } fsrds_host_state_t;
endpackage : fsrds_pkg

/* pkg/fsrds_if.sv */
`timescale 1ns/1ns
interface fsrds_if;
  logic sclk;
  logic cs_n;
  logic [3:0] io_out;
  logic [3:0] io_oe;
  logic [3:0] io;
  // undriven lines float high through pull-ups
  assign io = (io_out & io_oe) | ~io_oe;
  modport host(output sclk, output cs_n, output io_out, output io_oe);
  modport device(input sclk, input cs_n, input io);
endinterface : fsrds_if

/* rtl/fsrds_device.sv */
`timescale 1ns/1ns
module fsrds_device #(
  parameter int RECOV_CYC = fsrds_pkg::RST_RECOV_CYC,
  parameter int ENTRY_CYC = fsrds_pkg::DEEP_ENTRY_CYC,
  parameter int EXIT_CYC = fsrds_pkg::DEEP_EXIT_CYC
) (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  fsrds_if.device lnk,
  input wire logic i_busy,
  input wire logic i_wel_set,
  input wire logic i_sus_set,
  input wire logic i_quad_set,
  input wire logic i_param_load,
  input wire logic [7:0] i_param_data,
  input wire logic i_wrap_load,
  input wire logic [2:0] i_wrap_data,
  output logic o_wel,
  output logic o_sus,
  output logic o_quad,
  output logic [7:0] o_param,
  output logic [2:0] o_wrap,
  output logic o_abort,
  output logic o_recovering,
  output logic o_deep,
  output logic o_standby
);
  // link side, clocked by the host's serial clock
  logic frame_rst;
  logic fresh_reg;
  logic [2:0] cnt_reg;
  logic [2:0] idx;
  logic [7:0] spi_sh_reg;
  logic [3:0] nib_reg;
  logic [7:0] spi_byte_reg;
  logic [7:0] qpi_byte_reg;
  logic spi_tgl_reg;
  logic qpi_tgl_reg;

  assign frame_rst = lnk.cs_n | i_sys_rst;
  assign idx = fresh_reg ? 3'h0 : cnt_reg;

  // first edge of a frame restarts the count without a link-side reset
  always_ff @(posedge lnk.sclk or posedge frame_rst) begin
    if (frame_rst) begin
      fresh_reg <= 1'b1;
    end else begin
      fresh_reg <= 1'b0;
    end
  end

  always_ff @(posedge lnk.sclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      cnt_reg <= 3'h0;
      spi_sh_reg <= 8'h00;
      nib_reg <= 4'h0;
    end else begin
      cnt_reg <= idx + 3'h1;
      spi_sh_reg <= {spi_sh_reg[6:0], lnk.io[0]};
      nib_reg <= lnk.io;
    end
  end

  always_ff @(posedge lnk.sclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      spi_byte_reg <= 8'h00;
      spi_tgl_reg <= 1'b0;
    end else if (idx == 3'h7) begin
      spi_byte_reg <= {spi_sh_reg[6:0], lnk.io[0]};
      spi_tgl_reg <= ~spi_tgl_reg;
    end
  end

  always_ff @(posedge lnk.sclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      qpi_byte_reg <= 8'h00;
      qpi_tgl_reg <= 1'b0;
    end else if (idx[0]) begin
      qpi_byte_reg <= {nib_reg, lnk.io};
      qpi_tgl_reg <= ~qpi_tgl_reg;
    end
  end

  // crossing into the system clock; byte words stay stable for
  // several link edges, so only select, the toggles and count bits are synchronised
  logic [4:0] sync_a_reg;
  logic [4:0] sync_b_reg;
  logic [4:0] prev_reg;
  logic quad_reg;

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      sync_a_reg <= fsrds_pkg::SYNC_RESET_VAL;
      sync_b_reg <= fsrds_pkg::SYNC_RESET_VAL;
      prev_reg <= fsrds_pkg::SYNC_RESET_VAL;
    end else begin
      sync_a_reg <= {lnk.cs_n, spi_tgl_reg, qpi_tgl_reg,
                     cnt_reg != 3'h0, cnt_reg[0]};
      sync_b_reg <= sync_a_reg;
      prev_reg <= sync_b_reg;
    end
  end

  logic cs_fall;
  logic cs_rise;
  logic byte_ev;
  logic partial;
  logic [7:0] rx_byte;

  assign cs_fall = prev_reg[4] & ~sync_b_reg[4];
  assign cs_rise = ~prev_reg[4] & sync_b_reg[4];
  assign byte_ev = quad_reg ? (sync_b_reg[2] ^ prev_reg[2])
                            : (sync_b_reg[3] ^ prev_reg[3]);
  assign partial = quad_reg ? sync_b_reg[0] : sync_b_reg[1];
  assign rx_byte = quad_reg ? qpi_byte_reg : spi_byte_reg;

  // frame bookkeeping
  fsrds_pkg::fsrds_dev_state_t state_reg;
  fsrds_pkg::fsrds_dev_state_t state_next;
  logic first_reg;
  logic skip_reg;
  logic deep_fall_reg;
  logic armed_reg;
  logic udpd_reg;
  logic opcode_ev;
  logic go_reset;
  logic go_entry;
  logic go_wake;

  assign opcode_ev = byte_ev & first_reg & ~skip_reg
                     & ~lnk_idle_guard(state_reg);
  assign go_reset = opcode_ev & (rx_byte == fsrds_pkg::CMD_RST)
                    & armed_reg;
  assign go_entry = cs_rise & udpd_reg & ~skip_reg & ~partial
                    & (state_reg == fsrds_pkg::ST_STANDBY);
  assign go_wake = cs_rise & deep_fall_reg
                   & (state_reg == fsrds_pkg::ST_DEEP);

  function automatic logic lnk_idle_guard(
    input fsrds_pkg::fsrds_dev_state_t st);
    lnk_idle_guard = (st != fsrds_pkg::ST_STANDBY);
  endfunction : lnk_idle_guard

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      first_reg <= 1'b0;
      skip_reg <= 1'b1;
      deep_fall_reg <= 1'b0;
    end else if (cs_fall) begin
      first_reg <= 1'b1;
      skip_reg <= lnk_idle_guard(state_reg);
      deep_fall_reg <= (state_reg == fsrds_pkg::ST_DEEP);
    end else if (byte_ev) begin
      first_reg <= 1'b0;
    end
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      armed_reg <= 1'b0;
    end else if (go_reset) begin
      armed_reg <= 1'b0;
    end else if (opcode_ev) begin
      armed_reg <= (rx_byte == fsrds_pkg::CMD_RST_EN);
    end
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      udpd_reg <= 1'b0;
    end else if (cs_fall) begin
      udpd_reg <= 1'b0;
    end else if (opcode_ev) begin
      udpd_reg <= (rx_byte == fsrds_pkg::CMD_DEEP) & ~i_busy;
    end
  end

  // state and timing
  logic [fsrds_pkg::TMR_W-1:0] tmr_reg;
  logic tmr_zero;

  assign tmr_zero = (tmr_reg == '0);

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      fsrds_pkg::ST_STANDBY: begin
        if (go_reset) begin
          state_next = fsrds_pkg::ST_RECOVER;
        end else if (go_entry) begin
          state_next = fsrds_pkg::ST_ENTERING;
        end
      end
      fsrds_pkg::ST_RECOVER: begin
        if (tmr_zero) begin
          state_next = fsrds_pkg::ST_STANDBY;
        end
      end
      fsrds_pkg::ST_ENTERING: begin
        if (tmr_zero) begin
          state_next = fsrds_pkg::ST_DEEP;
        end
      end
      fsrds_pkg::ST_DEEP: begin
        if (go_wake) begin
          state_next = fsrds_pkg::ST_WAKING;
        end
      end
      fsrds_pkg::ST_WAKING: begin
        if (tmr_zero) begin
          state_next = fsrds_pkg::ST_STANDBY;
        end
      end
      default: begin
        state_next = fsrds_pkg::ST_STANDBY;
      end
    endcase
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      state_reg <= fsrds_pkg::ST_STANDBY;
    end else begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      tmr_reg <= '0;
    end else if (go_reset) begin
      tmr_reg <= fsrds_pkg::TMR_W'(RECOV_CYC - 1);
    end else if (go_entry) begin
      tmr_reg <= fsrds_pkg::TMR_W'(ENTRY_CYC - 1);
    end else if (go_wake) begin
      tmr_reg <= fsrds_pkg::TMR_W'(EXIT_CYC - 1);
    end else if (!tmr_zero) begin
      tmr_reg <= tmr_reg - 1'b1;
    end
  end

  // volatile settings; a reset overrides a same-cycle load on purpose
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_wel <= 1'b0;
      o_sus <= 1'b0;
      quad_reg <= 1'b0;
      o_param <= fsrds_pkg::PARAM_RESET_VAL;
      o_wrap <= fsrds_pkg::WRAP_RESET_VAL;
    end else if (go_reset) begin
      o_wel <= 1'b0;
      o_sus <= 1'b0;
      quad_reg <= 1'b0;
      o_param <= fsrds_pkg::PARAM_RESET_VAL;
      o_wrap <= fsrds_pkg::WRAP_RESET_VAL;
    end else if (state_reg == fsrds_pkg::ST_STANDBY) begin
      o_wel <= o_wel | i_wel_set;
      o_sus <= o_sus | i_sus_set;
      quad_reg <= quad_reg | i_quad_set;
      if (i_param_load) begin
        o_param <= i_param_data;
      end
      if (i_wrap_load) begin
        o_wrap <= i_wrap_data;
      end
    end
  end

  assign o_quad = quad_reg;

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_abort <= 1'b0;
      o_recovering <= 1'b0;
      o_deep <= 1'b0;
      o_standby <= 1'b1;
    end else begin
      o_abort <= go_reset;
      o_recovering <= (state_next == fsrds_pkg::ST_RECOVER);
      o_deep <= (state_next == fsrds_pkg::ST_DEEP);
      o_standby <= (state_next == fsrds_pkg::ST_STANDBY);
    end
  end
endmodule : fsrds_device

/* rtl/fsrds_host.sv */
`timescale 1ns/1ns
module fsrds_host #(
  parameter int RECOV_CYC = fsrds_pkg::RST_RECOV_CYC,
  parameter int ENTRY_CYC = fsrds_pkg::DEEP_ENTRY_CYC,
  parameter int EXIT_CYC = fsrds_pkg::DEEP_EXIT_CYC,
  parameter int WAKE_CYC = fsrds_pkg::WAKE_LOW_CYC,
  parameter int HALF_CYC = fsrds_pkg::SCLK_HALF_CYC
) (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  fsrds_if.host lnk
);
  fsrds_pkg::fsrds_host_state_t st_reg;
  logic [11:0] cmd_reg;
  logic [7:0] sh_reg;
  logic [3:0] edges_reg;
  logic [fsrds_pkg::TMR_W-1:0] tmr_reg;
  logic [fsrds_pkg::TMR_W-1:0] div_reg;
  logic sclk_reg;
  logic cs_n_reg;
  logic [3:0] io_reg;
  logic [3:0] oe_reg;
  logic armed_reg;
  logic start;
  logic quad;
  logic wake;
  logic [7:0] nsh;

  function automatic logic is_cmd(input logic [11:0] a);
    is_cmd = (a == fsrds_pkg::CMD_OFS);
  endfunction : is_cmd

  // a write refused in setup stays refused even if the host idles meanwhile
  assign start = i_psel & i_penable & o_pready & i_pwrite & ~o_pslverr
                 & is_cmd(i_paddr) & (st_reg == fsrds_pkg::H_IDLE);
  assign quad = cmd_reg[fsrds_pkg::CMD_QUAD_BIT];
  assign wake = cmd_reg[fsrds_pkg::CMD_WAKE_BIT];
  assign nsh = quad ? {sh_reg[3:0], 4'h0} : {sh_reg[6:0], 1'b0};

  // zero-wait slave: ready in every access phase
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_pready <= 1'b0;
      o_pslverr <= 1'b0;
      o_prdata <= 32'h0000_0000;
    end else begin
      o_pready <= i_psel & ~i_penable;
      o_pslverr <= i_psel & ~i_penable
                   & (~(is_cmd(i_paddr) | i_paddr == fsrds_pkg::STAT_OFS)
                      | (is_cmd(i_paddr) & i_pwrite
                         & st_reg != fsrds_pkg::H_IDLE));
      if (i_psel & ~i_penable & is_cmd(i_paddr)) begin
        o_prdata <= {20'h0_0000, cmd_reg};
      end else if (i_psel & ~i_penable) begin
        o_prdata <= {28'h000_0000, st_reg, armed_reg,
                     st_reg != fsrds_pkg::H_IDLE};
      end else begin
        o_prdata <= 32'h0000_0000;
      end
    end
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      st_reg <= fsrds_pkg::H_IDLE;
      cmd_reg <= fsrds_pkg::CMD_RESET_VAL;
      sh_reg <= 8'h00;
      edges_reg <= 4'h0;
      tmr_reg <= '0;
      div_reg <= '0;
      sclk_reg <= 1'b0;
      cs_n_reg <= 1'b1;
      io_reg <= 4'h0;
      oe_reg <= 4'h0;
      armed_reg <= 1'b0;
    end else begin
      case (st_reg)
        fsrds_pkg::H_IDLE: begin
          if (start) begin
            cmd_reg <= i_pwdata[11:0];
            cs_n_reg <= 1'b0;
            div_reg <= fsrds_pkg::TMR_W'(HALF_CYC - 1);
            sh_reg <= i_pwdata[fsrds_pkg::CMD_WAKE_BIT] ? 8'h00
                                                        : i_pwdata[7:0];
            edges_reg <= i_pwdata[fsrds_pkg::CMD_QUAD_BIT] ? 4'h2 : 4'h8;
            oe_reg <= i_pwdata[fsrds_pkg::CMD_QUAD_BIT] ? 4'hf : 4'h1;
            io_reg <= i_pwdata[fsrds_pkg::CMD_QUAD_BIT] ? i_pwdata[7:4]
                      : {3'h0, i_pwdata[7] & ~i_pwdata[9]};
            tmr_reg <= i_pwdata[fsrds_pkg::CMD_WAKE_BIT]
                       ? fsrds_pkg::TMR_W'(WAKE_CYC - 1)
                       : fsrds_pkg::TMR_W'(HALF_CYC - 1);
            st_reg <= (i_pwdata[fsrds_pkg::CMD_WAKE_BIT]
                       & ~i_pwdata[fsrds_pkg::CMD_DUMMY_BIT])
                      ? fsrds_pkg::H_LOW : fsrds_pkg::H_SHIFT;
          end
        end
        fsrds_pkg::H_SHIFT: begin
          if (div_reg != '0) begin
            div_reg <= div_reg - 1'b1;
          end else if (!sclk_reg) begin
            sclk_reg <= 1'b1;
            div_reg <= fsrds_pkg::TMR_W'(HALF_CYC - 1);
          end else begin
            sclk_reg <= 1'b0;
            div_reg <= fsrds_pkg::TMR_W'(HALF_CYC - 1);
            sh_reg <= nsh;
            io_reg <= quad ? nsh[7:4] : {3'h0, nsh[7]};
            edges_reg <= edges_reg - 4'h1;
            if (edges_reg == 4'h1) begin
              st_reg <= fsrds_pkg::H_LOW;
            end
          end
        end
        fsrds_pkg::H_LOW: begin
          if (tmr_reg != '0) begin
            tmr_reg <= tmr_reg - 1'b1;
          end else begin
            cs_n_reg <= 1'b1;
            oe_reg <= 4'h0;
            st_reg <= fsrds_pkg::H_HOLD;
            armed_reg <= ~wake & (cmd_reg[7:0] == fsrds_pkg::CMD_RST_EN);
            if (wake) begin
              tmr_reg <= fsrds_pkg::TMR_W'(EXIT_CYC - 1);
            end else if (armed_reg
                         & cmd_reg[7:0] == fsrds_pkg::CMD_RST) begin
              tmr_reg <= fsrds_pkg::TMR_W'(RECOV_CYC - 1);
            end else if (cmd_reg[7:0] == fsrds_pkg::CMD_DEEP) begin
              tmr_reg <= fsrds_pkg::TMR_W'(ENTRY_CYC - 1);
            end else begin
              tmr_reg <= fsrds_pkg::TMR_W'(fsrds_pkg::CMD_GAP_CYC - 1);
            end
          end
        end
        fsrds_pkg::H_HOLD: begin
          if (tmr_reg != '0) begin
            tmr_reg <= tmr_reg - 1'b1;
          end else begin
            st_reg <= fsrds_pkg::H_IDLE;
          end
        end
        default: begin
          st_reg <= fsrds_pkg::H_IDLE;
        end
      endcase
    end
  end

  assign lnk.sclk = sclk_reg;
  assign lnk.cs_n = cs_n_reg;
  assign lnk.io_out = io_reg;
  assign lnk.io_oe = oe_reg;
endmodule : fsrds_host

/* verification/fsrds_link_properties.sv */
`timescale 1ns/1ns
module fsrds_link_checker #(
  parameter int WAKE_CYC = fsrds_pkg::WAKE_LOW_CYC
) (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic [3:0] io_out,
  input wire logic [3:0] io_oe,
  input wire logic [3:0] io
);
  logic [7:0] rise_cnt_reg;
  logic [7:0] low_cnt_reg;
  logic quad_reg;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  // counts clear between frames but keep their last value at the select rise
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst || cs_n) begin
      rise_cnt_reg <= 8'h00;
      low_cnt_reg <= 8'h00;
      quad_reg <= 1'b0;
    end else begin
      if ($rose(sclk)) rise_cnt_reg <= rise_cnt_reg + 8'h01;
      if (low_cnt_reg != 8'hff) low_cnt_reg <= low_cnt_reg + 8'h01;
      if (io_oe == 4'hf) quad_reg <= 1'b1;
    end
  end
  AST_SCLK_IDLE: assert property (cs_n |-> !sclk)
    else $error("serial clock toggles outside a frame");
  AST_OE_IDLE: assert property (cs_n && $past(cs_n) |->
    io_oe == 4'h0)
    else $error("data lines driven outside a frame");
  AST_OE_WIDTH: assert property (io_oe != 4'h0 |->
    io_oe == 4'h1 || io_oe == 4'hf)
    else $error("data line enables neither single nor quad");
  AST_IO_SETUP: assert property ($rose(sclk) |-> $stable(io))
    else $error("data changed at a sampling edge");
  AST_SCLK_HALF: assert property ($rose(sclk) |-> sclk [*2])
    else $error("serial clock high phase too short");
  AST_GAP: assert property ($rose(cs_n) |-> cs_n [*4])
    else $error("next frame started too soon");
  AST_BYTE_ALIGN: assert property ($rose(cs_n) |->
    rise_cnt_reg[2:0] == 3'h0 || (quad_reg && !rise_cnt_reg[0]))
    else $error("frame ended off a byte boundary");
  AST_WAKE_LEN: assert property ($rose(cs_n) &&
    rise_cnt_reg == 8'h00 |-> low_cnt_reg >= WAKE_CYC - 1)
    else $error("wake pulse shorter than required");
  AST_CS_AFTER_FALL: assert property ($rose(cs_n) |->
    !$past(sclk) && !$past(sclk, 2))
    else $error("select rose too close to last clock edge");
  cover property ($rose(cs_n) && quad_reg);
  cover property ($rose(cs_n) && rise_cnt_reg == 8'h00);
  cover property ($rose(cs_n) && rise_cnt_reg == 8'h08);
endmodule : fsrds_link_checker

/* verification/flash_soft_reset_and_deep_sleep_bench.sv */
`timescale 1ns/1ns
module flash_soft_reset_and_deep_sleep_bench;
  localparam int RECOV = 100;
  localparam int ENTRY = 20;
  localparam int EXIT = 20;
  localparam int WAKE = 10;
  logic i_clk = 1'b0;
  logic i_sys_rst = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata, rd, tmp;
  logic pready, pslverr, err;
  logic busy = 1'b0, wel_set = 1'b0, sus_set = 1'b0, quad_set = 1'b0;
  logic param_load = 1'b0, wrap_load = 1'b0;
  logic [7:0] param_data = 8'h00, param, p, op;
  logic [2:0] wrap_data = 3'h0, wrap, w;
  logic write_enable_latch_bit, suspend_status_bit, quad, abort, recovering, deep, standby;
  int miscompares = 0, n_checks = 0, aborts = 0, recov_len = 0;
  int seed = 32'h3636_3509;
  wire [31:0] set_seen = {18'h0, quad, write_enable_latch_bit, suspend_status_bit, param, wrap};
  fsrds_if lnk_if();
  always #2 i_clk = ~i_clk;
  fsrds_host #(.RECOV_CYC(RECOV), .ENTRY_CYC(ENTRY), .EXIT_CYC(EXIT),
    .WAKE_CYC(WAKE)) fsrds_host_inst (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
    .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
    .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(pslverr), .lnk(lnk_if));
  fsrds_device #(.RECOV_CYC(RECOV), .ENTRY_CYC(ENTRY), .EXIT_CYC(EXIT))
    fsrds_device_inst (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .lnk(lnk_if),
    .i_busy(busy), .i_wel_set(wel_set), .i_sus_set(sus_set),
    .i_quad_set(quad_set), .i_param_load(param_load),
    .i_param_data(param_data), .i_wrap_load(wrap_load),
    .i_wrap_data(wrap_data), .o_wel(write_enable_latch_bit), .o_sus(suspend_status_bit), .o_quad(quad),
    .o_param(param), .o_wrap(wrap), .o_abort(abort),
    .o_recovering(recovering), .o_deep(deep), .o_standby(standby));
  fsrds_link_checker #(.WAKE_CYC(WAKE)) fsrds_link_checker_inst (
    .i_clk(i_clk), .i_sys_rst(i_sys_rst), .sclk(lnk_if.sclk),
    .cs_n(lnk_if.cs_n), .io_out(lnk_if.io_out), .io_oe(lnk_if.io_oe),
    .io(lnk_if.io));
  always @(posedge i_clk) begin
    if (abort === 1'b1) aborts <= aborts + 1;
    if (recovering === 1'b1) recov_len <= recov_len + 1;
  end
  function automatic logic [31:0] exp_set(input logic q, input logic k,
    input logic [7:0] pv, input logic [2:0] wv);
    return {18'h0, q, k, k, pv, wv};
  endfunction : exp_set
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : print_verdict
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask : check
  // request held until the rising edge that samples pready high
  task automatic apb(input logic wr, input logic [11:0] a,
    input logic [31:0] d);
    int n;
    n = 0;
    @(posedge i_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge i_clk);
    penable <= 1'b1;
    do begin
      @(posedge i_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) miscompares++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic poll;
    int n;
    n = 0;
    do begin
      apb(1'b0, fsrds_pkg::STAT_OFS, 32'h0000_0000);
      n++;
    end while (rd[0] !== 1'b0 && n < 400);
    if (n >= 400) miscompares++;
  endtask : poll
  // f: dummy byte, wake pulse, quad lines
  task automatic cmd(input logic [7:0] o, input logic [2:0] f);
    apb(1'b1, fsrds_pkg::CMD_OFS, {21'h0, f, o});
    check({31'h0, err}, 32'h0000_0000);
    poll();
  endtask : cmd
  task automatic wait_mode(input logic d);
    int n;
    n = 0;
    while ((d ? deep : standby) !== 1'b1 && n < 60) begin
      @(negedge i_clk);
      n++;
    end
    check({31'h0, d ? deep : standby}, 32'h0000_0001);
  endtask : wait_mode
  task automatic load(input logic q);
    tmp = $random(seed);
    p = tmp[7:0];
    w = tmp[10:8];
    @(posedge i_clk);
    {wel_set, sus_set, param_load, wrap_load, quad_set} <= {4'hf, q};
    param_data <= p;
    wrap_data <= w;
    @(posedge i_clk);
    {wel_set, sus_set, param_load, wrap_load, quad_set} <= 5'h00;
    repeat (2) @(posedge i_clk);
  endtask : load
  initial begin
    // far beyond the thousand or so cycles the tests need
    #100000;
    miscompares++;
    print_verdict();
  end
  initial begin
    repeat (12) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    repeat (4) @(posedge i_clk);
    check({29'h0, standby, deep, recovering}, 32'h0000_0004);
    apb(1'b0, 12'h008, 32'h0000_0000);
    check({31'h0, err}, 32'h0000_0001);
    $display("power-up and unmapped access done");
    for (int q = 0; q < 2; q++) begin
      load(q[0]);
      check(set_seen, exp_set(q[0], 1'b1, p, w));
      aborts = 0;
      recov_len = 0;
      cmd(fsrds_pkg::CMD_RST_EN, {2'b00, q[0]});
      cmd(fsrds_pkg::CMD_RST, {2'b00, q[0]});
      wait_mode(1'b0);
      check(aborts, 32'h0000_0001);
      check(recov_len, RECOV);
      check(set_seen, exp_set(1'b0, 1'b0, fsrds_pkg::PARAM_RESET_VAL,
        fsrds_pkg::WRAP_RESET_VAL));
      apb(1'b0, fsrds_pkg::CMD_OFS, 32'h0000_0000);
      check(rd, {21'h0, 2'b00, q[0], fsrds_pkg::CMD_RST});
      $display("reset pair done, quad %0d", q);
    end
    load(1'b0);
    aborts = 0;
    for (int i = 0; i < 3; i++) begin
      apb(1'b1, fsrds_pkg::CMD_OFS, {24'h0, fsrds_pkg::CMD_RST_EN});
      apb(1'b1, fsrds_pkg::CMD_OFS, {24'h0, fsrds_pkg::CMD_RST});
      check({31'h0, err}, 32'h0000_0001);
      poll();
      tmp = $random(seed);
      op = tmp[7:0];
      if (op == 8'h66 || op == 8'h99 || op == 8'h79) op = 8'h00;
      cmd(op, 3'b000);
      cmd(fsrds_pkg::CMD_RST, 3'b000);
    end
    check(aborts, 32'h0000_0000);
    check(set_seen, exp_set(1'b0, 1'b1, p, w));
    $display("disarm and lone reset done");
    @(posedge i_clk);
    busy <= 1'b1;
    cmd(fsrds_pkg::CMD_DEEP, 3'b000);
    repeat (10) @(posedge i_clk);
    check({30'h0, deep, standby}, 32'h0000_0001);
    @(posedge i_clk);
    busy <= 1'b0;
    cmd(fsrds_pkg::CMD_DEEP, 3'b000);
    wait_mode(1'b1);
    cmd(8'h00, 3'b110);
    wait_mode(1'b0);
    check(set_seen, exp_set(1'b0, 1'b1, p, w));
    cmd(fsrds_pkg::CMD_DEEP, 3'b000);
    wait_mode(1'b1);
    cmd(8'h00, 3'b010);
    wait_mode(1'b0);
    $display("deep sleep entry and wake done");
    print_verdict();
  end
endmodule : flash_soft_reset_and_deep_sleep_bench
